// >>> logic/floppy_host_timing.v
// Purpose: S-100 decode, board select, bit/byte timing and wait handshake
// Assumes: all pins asynchronous to pclk; recovered clock far slower than pclk
// Notes: registers over APB; one clock domain
//
// Function
// RL1: separator stays cleared with shift clock high while its clear input is low.
// RL2: separator aligns bit phase using phasing input during runs of zeros.
// RL3: recovered data high after a data pulse; sampled on recovered clock rise.
// RL4: recovered shift clock has one rising edge per bit cell.
// RL5: transceivers enabled when selected; toward CPU while read strobe high.
// RL6: internal reset from power-on, external clear or supply monitor.
// RL7: io write to switch nibble with low nibble E/F, gated by SOUT, clocks select.
// RL8: select flip-flop loads A0 on matching io write; one selects.
// RL9: reset state of select flip-flop is a build option.
// RL10: board select needs A15:12 = E on memory reference and select or extended bits.
// RL11: selected with A11 low enables program memory E000-E7FF.
// RL12: selected with A11 high decodes eight 256-byte segments E800-EFFF.
// RL13: outside writes local counters cleared; bit shift follows recovered clock.
// RL14: during write bit timing comes from free-running local oscillator.
// RL15: rate bits pick oscillator division per board variant.
// RL16: divided clock further divided by ten then two forms bit clock.
// RL17: bit shift counter divides by eight, counting 1 to 8, for byte-ready.
// RL18: on read byte-ready marks full byte; CPU reads within one bit time.
// RL19: on write byte-ready follows loading the CPU byte into the serializer.
// RL20: count seven during write loads shift registers as count enters ready.
// RL21: shift registers move on the inverse of bit shift.
// RL22: CPU held in wait until the one-bit transfer window arrives.
// RL23: byte-synchronous access waits until byte-ready rises.
// RL24: retriggerable timeout per access; ready low only while waiting and not expired.
// RL25: timeout length is a parameter longer than a slow byte time.
`timescale 1ns/1ns
`default_nettype none
`include "floppy_timing_regs.vh"

module floppy_host_timing #(
    parameter SELECT_AT_RESET = 1'b1,
    parameter EXT_ADDRESSING = 1'b0,
    parameter VARIANT_D = 1'b0,
    parameter [15:0] TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [15:0] bus_addr,
    input wire [3:0] ext_addr,
    input wire [7:0] bus_dout,
    input wire [3:0] port_switch,
    input wire bus_pwr_n,
    input wire bus_pdbin,
    input wire bus_sout,
    input wire bus_sinp,
    input wire poc_n,
    input wire extclr_n,
    input wire supply_fail,
    input wire recovered_shift_clock,
    input wire recovered_clock_bit,
    input wire recovered_data_bit,
    output reg [7:0] bus_din,
    output reg board_select_n,
    output reg rom_enable_n,
    output reg [7:0] segment_select_n,
    output reg xcvr_enable,
    output reg xcvr_to_cpu,
    output wire prdy,
    output reg separator_clear_n,
    output reg separator_sync_n,
    output reg [1:0] rate_select,
    output reg write_data_out,
    output reg internal_reset
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers
// every backplane and separator pin is asynchronous to pclk, so all of them
// pass two flops before any decode reads them; this costs three pclk edges of
// latency on selects and on the wait line, which the cpu strobes easily cover.
// the synchroniser flops reset to zero, so the active-low reset pins read as
// asserted for a few edges after presetn rises: internal reset therefore
// always covers that window and the select flop starts from its build value.
// the clock bit from the separator is synchronised with the rest but not used
// here; it belongs to the address-mark compare, which lives outside this block.
localparam SW = 42;
wire [SW-1:0] raw = {bus_addr, ext_addr, bus_dout, port_switch, bus_pwr_n, bus_pdbin,
                     bus_sout, bus_sinp, poc_n, extclr_n, supply_fail,
                     recovered_shift_clock, recovered_clock_bit, recovered_data_bit};
reg [SW-1:0] meta_q;
reg [SW-1:0] sync_q;
genvar g;
generate
    for (g = 0; g < SW; g = g + 1) begin : sync_bit
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                meta_q[g] <= 1'b0;
                sync_q[g] <= 1'b0;
            end else if (clk_en) begin
                meta_q[g] <= raw[g];
                sync_q[g] <= meta_q[g];
            end
        end
    end
endgenerate

wire [15:0] a = sync_q[41:26];
wire [3:0] ea = sync_q[25:22];
wire [7:0] dout_s = sync_q[21:14];
wire [3:0] sw_s = sync_q[13:10];
wire pwr_n_s = sync_q[9];
wire pdbin_s = sync_q[8];
wire sout_s = sync_q[7];
wire sinp_s = sync_q[6];
wire rst_req = !sync_q[5] || !sync_q[4] || sync_q[3]; // RL6
wire rclk_s = sync_q[2];
wire rdat_s = sync_q[0];

////////////////////////////////////////////////////////////////////////////////
// registers
reg [3:0] ctrl_q;
wire wr_mode = ctrl_q[`CTRL_WRITE_BIT];
wire [1:0] rate = ctrl_q[`CTRL_RATE_HI:`CTRL_RATE_LO];
reg select_q;
reg io_match_q;
reg access_q;
reg wait_q;
reg [15:0] timer_q;
reg [4:0] osc_q;
reg [1:0] rdiv_q;
reg [3:0] div10_q;
reg half_q;
reg shift_q;
reg [3:0] cnt_q;
reg [7:0] ser_q;
reg [7:0] des_q;
reg [7:0] tx_q;
reg [7:0] rx_q;
reg bit_q;
reg rclk_q;

wire mem_ref = !sout_s && !sinp_s;
wire ext_ok = EXT_ADDRESSING ? (ea == `ALL_ONES_NIBBLE) : 1'b0;
wire board_sel = mem_ref && (a[15:12] == `BOARD_NIBBLE) && (select_q || ext_ok); // RL10
wire io_match = (a[7:4] == sw_s) && (a[3:1] == 3'h7) && !pwr_n_s && sout_s; // RL7
wire strobe = pdbin_s || !pwr_n_s;
wire access = board_sel && strobe;
wire access_start = access && !access_q;
wire seg_hit = board_sel && a[11];
wire rd_sync = access_start && seg_hit && (a[10:8] == `SEG_READ_SYNC) && pdbin_s;
wire wr_sync = access_start && seg_hit && (a[10:8] == `SEG_WRITE_SYNC) && !pwr_n_s;

// rate division: terminal count of the prescaler per variant
reg [1:0] rdiv_max;
always @* begin
    if (VARIANT_D) begin
        rdiv_max = (rate == 2'h1) ? 2'h1 : 2'h3; // RL15
    end else begin
        rdiv_max = (rate == 2'h3) ? 2'h0 : 2'h1; // RL15
    end
end

wire osc_tick = (osc_q + `OSC_STEP) >= `OSC_WRAP;
wire pre_tick = osc_tick && (rdiv_q == rdiv_max);
wire bit_shift = wr_mode ? half_q : rclk_s; // RL13 RL14
wire shift_rise = bit_shift && !shift_q;
wire shift_fall = !bit_shift && shift_q;
wire byte_ready = (cnt_q == `COUNT_READY);
wire ready_rise = shift_rise && (cnt_q == `COUNT_LOAD);
wire expired = (timer_q == 16'h0000);
assign prdy = !(wait_q && !expired); // RL24

////////////////////////////////////////////////////////////////////////////////
// board select, decode and transceiver control
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        internal_reset <= 1'b1;
        select_q <= 1'b0;
        io_match_q <= 1'b0;
        board_select_n <= 1'b1;
        rom_enable_n <= 1'b1;
        segment_select_n <= 8'hFF;
        xcvr_enable <= 1'b0;
        xcvr_to_cpu <= 1'b0;
    end else if (clk_en) begin
        internal_reset <= rst_req;
        io_match_q <= io_match;
        if (rst_req) begin
            select_q <= SELECT_AT_RESET; // RL9
        end else if (io_match && !io_match_q) begin
            select_q <= a[0]; // RL8
        end
        board_select_n <= !board_sel;
        rom_enable_n <= !(board_sel && !a[11]); // RL11
        segment_select_n <= seg_hit ? ~(8'h01 << a[10:8]) : 8'hFF; // RL12
        xcvr_enable <= board_sel; // RL5
        xcvr_to_cpu <= pdbin_s; // RL5
    end
end

////////////////////////////////////////////////////////////////////////////////
// local bit timing; dividers held clear outside writes so a write starts in phase, oscillator runs free
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        osc_q <= 5'h00;
        rdiv_q <= 2'h0;
        div10_q <= 4'h0;
        half_q <= 1'b0;
    end else if (clk_en) begin
        osc_q <= osc_tick ? osc_q + `OSC_STEP - `OSC_WRAP : osc_q + `OSC_STEP; // RL14
        if (!wr_mode || internal_reset) begin
            rdiv_q <= 2'h0; // RL13
            div10_q <= 4'h0;
            half_q <= 1'b0;
        end else begin
            if (osc_tick) begin
                rdiv_q <= (rdiv_q == rdiv_max) ? 2'h0 : rdiv_q + 2'h1;
            end
            if (pre_tick) begin
                div10_q <= (div10_q == `BIT_DIV_TEN) ? 4'h0 : div10_q + 4'h1; // RL16
                if (div10_q == `BIT_DIV_TEN) begin
                    half_q <= !half_q; // RL16
                end
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// byte timing and shift registers
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        shift_q <= 1'b0;
        rclk_q <= 1'b0;
        bit_q <= 1'b0;
        cnt_q <= `COUNT_FIRST;
        ser_q <= 8'h00;
        des_q <= 8'h00;
        rx_q <= 8'h00;
        write_data_out <= 1'b0;
    end else if (clk_en) begin
        shift_q <= bit_shift;
        rclk_q <= rclk_s;
        if (rclk_s && !rclk_q) begin
            bit_q <= rdat_s; // RL3
        end
        if (internal_reset) begin
            cnt_q <= `COUNT_FIRST;
        end else if (shift_rise) begin
            cnt_q <= byte_ready ? `COUNT_FIRST : cnt_q + 4'h1; // RL17
        end
        if (ready_rise && wr_mode) begin
            ser_q <= tx_q; // RL20
        end else if (shift_fall) begin
            ser_q <= {ser_q[6:0], 1'b0}; // RL21
            des_q <= {des_q[6:0], bit_q}; // RL21
            write_data_out <= wr_mode && ser_q[7];
        end
        if (ready_rise && !wr_mode) begin
            rx_q <= {des_q[6:0], bit_q}; // RL18
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// cpu wait handshake with retriggerable timeout
// the timer restarts on every board access, not only on synchronous ones, so a
// cpu that keeps touching the board never sees a stale expiry; a broken
// separator can stall the cpu for at most one timeout per access.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        access_q <= 1'b0;
        wait_q <= 1'b0;
        timer_q <= 16'h0000;
        tx_q <= 8'h00;
        bus_din <= 8'h00;
    end else if (clk_en) begin
        access_q <= access;
        if (access_start) begin
            timer_q <= TIMEOUT_CYCLES; // RL24 RL25
        end else if (!expired) begin
            timer_q <= timer_q - 16'h0001;
        end
        // a new request wins over a byte-ready in the same cycle
        if (rd_sync || wr_sync) begin
            wait_q <= 1'b1; // RL22 RL23
        end else if (ready_rise || internal_reset) begin
            wait_q <= 1'b0; // RL23 RL19
        end
        if (wr_sync) begin
            tx_q <= dout_s;
        end
        bus_din <= rx_q; // RL18
    end
end

////////////////////////////////////////////////////////////////////////////////
// separator control pins
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        separator_clear_n <= 1'b1;
        separator_sync_n <= 1'b1;
        rate_select <= 2'h0;
    end else if (clk_en) begin
        separator_clear_n <= !wr_mode; // RL1
        separator_sync_n <= !ctrl_q[`CTRL_SYNC_BIT]; // RL2
        rate_select <= rate; // RL15
    end
end

////////////////////////////////////////////////////////////////////////////////
// apb slave: zero wait, read data captured in the setup cycle
wire mapped = (paddr == `CTRL_OFFSET) || (paddr == `STATUS_OFFSET);
assign pready = clk_en;
assign pslverr = psel && penable && (!mapped || (pwrite && paddr == `STATUS_OFFSET));

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_q <= `CTRL_RESET;
        prdata <= 32'h00000000;
    end else if (clk_en) begin
        if (psel && penable && pwrite && paddr == `CTRL_OFFSET) begin
            ctrl_q <= pwdata[3:0];
        end
        if (psel && !penable) begin
            if (paddr == `CTRL_OFFSET) begin
                prdata <= {28'h0000000, ctrl_q};
            end else if (paddr == `STATUS_OFFSET) begin
                prdata <= {16'h0000, rx_q, !expired ? 1'b0 : 1'b1, wait_q, select_q, cnt_q, byte_ready};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end
end

endmodule // floppy_host_timing
`default_nettype wire

// >>> common/floppy_timing_regs.vh
// Purpose: constants for the floppy host decode and bit/byte timing block
// Assumes: 125 MHz pclk, APB with 32-bit data
// Notes: offsets are byte addresses
`ifndef FLOPPY_TIMING_REGS_VH
`define FLOPPY_TIMING_REGS_VH

`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04

`define CTRL_WRITE_BIT 0
`define CTRL_RATE_LO 1
`define CTRL_RATE_HI 2
`define CTRL_SYNC_BIT 3
`define CTRL_RESET 4'h0

`define ST_BYTE_READY_BIT 0
`define ST_COUNT_LO 1
`define ST_COUNT_HI 4
`define ST_SELECT_BIT 5
`define ST_WAIT_BIT 6
`define ST_EXPIRED_BIT 7
`define ST_RX_LO 8
`define ST_RX_HI 15

`define CLK_MHZ 125
// 10 MHz local oscillator as a fractional step: 125 / 10 = 25 / 2
`define OSC_STEP 5'h02
`define OSC_WRAP 5'h19
`define BIT_DIV_TEN 4'h9
`define COUNT_FIRST 4'h1
`define COUNT_LOAD 4'h7
`define COUNT_READY 4'h8

`define BOARD_NIBBLE 4'hE
`define ALL_ONES_NIBBLE 4'hF
`define SEG_READ_SYNC 3'h5
`define SEG_WRITE_SYNC 3'h6

// longer than one byte at 125 kHz (64 us)
// 100 us of pclk, sized to the 16-bit timer so nothing is cut on assignment
`define TIMEOUT_CYCLES 16'h30D4

`endif

// >>> test/floppy_host_timing_asserts.sv
// Purpose: port-level checks for floppy_host_timing
// Assumes: one pclk domain, presetn async active low
// Notes: bound to every instance after the module
`timescale 1ns/1ns
`default_nettype none
module floppy_host_timing_asserts #(
    parameter [15:0] TIMEOUT_CYCLES = 16'd200
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic poc_n,
    input wire logic extclr_n,
    input wire logic supply_fail,
    input wire logic board_select_n,
    input wire logic rom_enable_n,
    input wire logic [7:0] segment_select_n,
    input wire logic xcvr_enable,
    input wire logic prdy,
    input wire logic separator_clear_n,
    input wire logic [1:0] rate_select,
    input wire logic internal_reset
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
// shadow of the control word, so outputs can be tied to what software wrote
logic [15:0] low_q;
logic [3:0] ctrl_q;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        low_q <= 16'h0000;
        ctrl_q <= 4'h0;
    end else begin
        low_q <= prdy ? 16'h0000 : low_q + 16'h0001;
        if (psel && penable && pready && pwrite && paddr == 8'h00) ctrl_q <= pwdata[3:0];
    end
end
ready_follows_en_a: assert property (pready == clk_en) else $error("pready differs from clk_en");
rom_needs_select_a: assert property (!rom_enable_n |-> !board_select_n) else $error("rom without select");
segment_one_hot_a: assert property ($countones(~segment_select_n) <= 1 &&
    (&segment_select_n || (!board_select_n && rom_enable_n))) else $error("segment selects malformed");
xcvr_select_a: assert property (xcvr_enable == !board_select_n) else $error("transceiver enable wrong");
reset_sources_a: assert property (!poc_n || !extclr_n || supply_fail |-> ##[1:4] internal_reset)
    else $error("internal reset missing");
write_clears_sep_a: assert property ($stable(ctrl_q) [*2] |-> separator_clear_n == !ctrl_q[0])
    else $error("separator clear wrong");
rate_follows_ctrl_a: assert property ($stable(ctrl_q) [*2] |-> rate_select == ctrl_q[2:1])
    else $error("rate select wrong");
wait_bounded_a: assert property (low_q <= TIMEOUT_CYCLES + 16'd8) else $error("wait outlasts timeout");
endmodule // floppy_host_timing_asserts
bind floppy_host_timing floppy_host_timing_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (.*);
`default_nettype wire

// >>> test/separator_model.sv
// Purpose: behavioural data separator facing floppy_host_timing
// Assumes: bit cell of 2*HALF pclk cycles, every cell holds a data pulse unless sync is asserted
// Notes: no phase jitter; sync only forces zero cells
`timescale 1ns/1ns
`default_nettype none
module separator_model #(
    parameter integer HALF = 20
) (
    input wire logic pclk,
    input wire logic separator_clear_n,
    input wire logic separator_sync_n,
    output logic recovered_shift_clock = 1'b1,
    output logic recovered_clock_bit = 1'b0,
    output logic recovered_data_bit = 1'b0
);
integer cnt_q = 0;
always @(posedge pclk) begin
    if (!separator_clear_n) begin
        recovered_shift_clock <= 1'b1;
        cnt_q <= 0;
    end else if (cnt_q < HALF - 1) begin
        cnt_q <= cnt_q + 1;
    end else begin
        cnt_q <= 0;
        recovered_shift_clock <= ~recovered_shift_clock;
        // lines move on the falling half so they are settled at the rise
        if (recovered_shift_clock) begin
            recovered_clock_bit <= 1'b1;
            recovered_data_bit <= separator_sync_n;
        end
    end
end
endmodule // separator_model
`default_nettype wire

// >>> test/floppy_host_decode_bit_byte_timing_tb_top.sv
// Purpose: self-checking bench for floppy_host_timing
// Assumes: 125 MHz pclk, separator cells of 40 cycles
// Notes: timeout shortened so one slow write byte outlasts it
`timescale 1ns/1ns
`default_nettype none
`include "floppy_timing_regs.vh"
module floppy_host_decode_bit_byte_timing_tb_top;
localparam [15:0] TO = 16'd3000;
localparam integer HALF = 20;
logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [7:0] paddr = 8'h00, bus_dout = 8'h00;
logic [31:0] pwdata = 32'h0, rd, s;
logic [15:0] bus_addr = 16'h0000;
logic [3:0] ext_addr = 4'h0, port_switch = 4'h3, r;
logic bus_pwr_n = 1'b1, bus_pdbin = 1'b0, bus_sout = 1'b0, bus_sinp = 1'b0, err;
logic poc_n = 1'b1, extclr_n = 1'b1, supply_fail = 1'b0;
wire [31:0] prdata;
wire [7:0] bus_din, segment_select_n;
wire [1:0] rate_select;
wire pready, pslverr, board_select_n, rom_enable_n, xcvr_enable, xcvr_to_cpu, prdy, internal_reset;
wire separator_clear_n, separator_sync_n, write_data_out;
wire recovered_shift_clock, recovered_clock_bit, recovered_data_bit;
integer failures = 0, tests_run = 0, n, i;
floppy_host_timing #(.TIMEOUT_CYCLES(TO)) uut (.*);
separator_model #(.HALF(HALF)) sep (.*);
always #4 pclk = ~pclk;
////////////////////////////////////////////////////////////////////////
task chk(input logic ok, input string m);
    tests_run = tests_run + 1;
    if (ok !== 1'b1) begin
        failures = failures + 1;
        $display("ERROR %0t: %s", $time, m);
    end
endtask
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task bus(input logic [15:0] a, input logic rdn, input logic wrn, input logic so);
    @(posedge pclk);
    bus_addr <= a;
    bus_pdbin <= rdn;
    bus_pwr_n <= wrn;
    bus_sout <= so;
    repeat (5) @(posedge pclk);
endtask
// n counts edges from the strobe until the wait is released
task bsync(input logic [15:0] a, input logic rdn, input logic wrn);
    bus(a, rdn, wrn, 1'b0);
    chk(prdy === 1'b0, "no wait");
    n = 5;
    while (prdy !== 1'b1 && n < 9000) begin
        @(posedge pclk);
        n = n + 1;
    end
    bus(16'h0000, 1'b0, 1'b1, 1'b0);
endtask
function integer bit_cycles(input logic [3:0] c);
    bit_cycles = !c[0] ? 2 * HALF : (c[2:1] == 2'b11 ? 250 : 500);
endfunction
task final_report;
    $display("tests %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    s = $urandom(32'hd965);
    s = $urandom;
    port_switch <= s[3:0];
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, `CTRL_OFFSET, 32'h0);
    chk(rd === 32'h0 && err === 1'b0, "ctrl reset");
    apb(1'b1, `CTRL_OFFSET, {28'h0, s[7:4]});
    apb(1'b0, `CTRL_OFFSET, 32'h0);
    chk(rd === {28'h0, s[7:4]}, "ctrl readback");
    apb(1'b1, `STATUS_OFFSET, 32'hFFFFFFFF);
    chk(err === 1'b1, "status write");
    apb(1'b0, 8'h0C, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped read");
    apb(1'b1, `CTRL_OFFSET, 32'h0);
    $display("registers done");
    bus({8'h00, port_switch, 4'hE}, 1'b0, 1'b0, 1'b1);
    bus(16'hE000, 1'b0, 1'b1, 1'b0);
    chk(board_select_n === 1'b1 && rom_enable_n === 1'b1, "deselect");
    bus({8'h00, port_switch, 4'hF}, 1'b0, 1'b0, 1'b1);
    bus({8'h00, ~port_switch, 4'hE}, 1'b0, 1'b0, 1'b1);
    bus(16'hE000 | {5'h00, s[18:8]}, s[19], 1'b1, 1'b0);
    chk(rom_enable_n === 1'b0 && segment_select_n === 8'hFF, "rom");
    chk(xcvr_enable === 1'b1 && xcvr_to_cpu === s[19], "transceiver");
    for (i = 0; i < 8; i = i + 1) begin
        s = $urandom;
        bus({5'h1D, i[2:0], s[7:0]}, s[8], 1'b1, 1'b0);
        chk(segment_select_n === ~(8'h01 << i) && rom_enable_n === 1'b1, "segment");
    end
    $display("decode done");
    bsync(16'hED00, 1'b1, 1'b1);
    bsync(16'hED00, 1'b1, 1'b1);
    chk(n >= 8 * bit_cycles(4'h0) - 20 && n <= 8 * bit_cycles(4'h0) + 5, "read byte time");
    chk(bus_din === 8'hFF, "read byte");
    for (i = 0; i < 2; i = i + 1) begin
        r = i ? 4'h5 : 4'h7;
        apb(1'b1, `CTRL_OFFSET, {28'h0, r});
        s = $urandom;
        bus_dout <= s[7:0];
        bsync(16'hEE00, 1'b0, 1'b0);
        // at the slow rate the first wait runs into the timeout; a second one
        // would then be released early by byte-ready, so it is only made at the fast rate
        if (i == 0) bsync(16'hEE00, 1'b0, 1'b0);
        apb(1'b0, `STATUS_OFFSET, 32'h0);
        chk(i ? (n >= TO - 5 && n <= TO + 8) :
            (n >= 8 * bit_cycles(r) - 20 && n <= 8 * bit_cycles(r) + 5 && rd[7] === 1'b0), "write wait");
    end
    $display("sync done");
    apb(1'b1, `CTRL_OFFSET, 32'h0);
    bus({8'h00, port_switch, 4'hE}, 1'b0, 1'b0, 1'b1);
    bus(16'h0000, 1'b0, 1'b1, 1'b0);
    for (i = 0; i < 3; i = i + 1) begin
        poc_n <= i != 0;
        extclr_n <= i != 1;
        supply_fail <= i == 2;
        repeat (6) @(posedge pclk);
        chk(internal_reset === 1'b1, "reset source");
        poc_n <= 1'b1;
        extclr_n <= 1'b1;
        supply_fail <= 1'b0;
        repeat (8) @(posedge pclk);
        chk(internal_reset === 1'b0, "reset stuck");
    end
    apb(1'b0, `STATUS_OFFSET, 32'h0);
    chk(rd[5] === 1'b1, "select after reset");
    $display("reset done");
    final_report;
end
initial begin
    repeat (40000) @(posedge pclk);
    failures = failures + 1;
    $display("ERROR %0t: watchdog", $time);
    final_report;
end
endmodule // floppy_host_decode_bit_byte_timing_tb_top
`default_nettype wire
